// File: dv/gpb_pad_model.sv
// Model of the external circuitry that resolves every pin level.
module gpb_pad_model (
   input  wire logic [63:0] pad_out,
   input  wire logic [63:0] pad_oe,
   input  wire logic [63:0] pad_pull_up,
   input  wire logic [63:0] pad_pull_down,
   input  wire logic [63:0] ext_val,
   input  wire logic [63:0] ext_en,
   output logic      [63:0] pad_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // A pin that nobody drives or pulls shows the inverse of the external value.
   always_comb begin
      for (int i = 0; i < 64; i++) begin
         if (pad_oe[i]) pad_in[i] = pad_out[i];
         else if (ext_en[i]) pad_in[i] = ext_val[i];
         else if (pad_pull_up[i]) pad_in[i] = 1'b1;
         else if (pad_pull_down[i]) pad_in[i] = 1'b0;
         else pad_in[i] = ~ext_val[i];
      end
   end
endmodule // gpb_pad_model

// File: dv/gpb_port_block_properties.sv
// Concurrent checks on the ports of the I/O port block.
module gpb_port_block_chk
   import gpb_pkg::*;
#(
   parameter int NUM_PORTS = GPB_NUM_PORTS,
   parameter int PLI_PORTS = GPB_PLI_PORTS
) (
   input wire logic                            clk,
   input wire logic                            resetn,
   input wire logic                            psel,
   input wire logic                            penable,
   input wire logic                            pready,
   input wire logic                            pslverr,
   input wire logic                            hold_mode,
   input wire logic [NUM_PORTS*GPB_PORT_W-1:0] pad_in,
   input wire logic [NUM_PORTS*GPB_PORT_W-1:0] pad_out,
   input wire logic [NUM_PORTS*GPB_PORT_W-1:0] pad_oe,
   input wire logic [NUM_PORTS*GPB_PORT_W-1:0] pad_ie,
   input wire logic [NUM_PORTS*GPB_PORT_W-1:0] pad_pull_up,
   input wire logic [NUM_PORTS*GPB_PORT_W-1:0] pad_pull_down,
   input wire logic [PLI_PORTS*GPB_PORT_W-1:0] pli_in,
   input wire logic [NUM_PORTS-1:0]            port_irq,
   input wire logic                            irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   ready_time_a: assert property (psel && penable && !$past(penable) |=> pready)
      else $error("access phase not answered in two cycles");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   reset_idle_a: assert property ($rose(resetn) |->
      (pad_oe | pad_ie | pad_pull_up | pad_pull_down) == '0)
      else $error("pad driver active after reset");
   pull_clash_a: assert property ((pad_pull_up & pad_pull_down) == '0)
      else $error("pull-up and pull-down both on");
   hold_keep_a: assert property (hold_mode [*2] |=>
      $stable(pad_out) && $stable(pad_oe) && $stable(pad_ie))
      else $error("pad moved during hold");
   irq_or_a: assert property (irq == (|port_irq))
      else $error("irq differs from port requests");
   irq_sticky_a: assert property (port_irq != '0 && !psel && !$past(psel) |=>
      (port_irq & $past(port_irq)) == $past(port_irq))
      else $error("port request dropped without a clear");
   pli_follow_a: assert property ((pad_ie[7:0] == 8'hff && $stable(pad_in[7:0])) [*5] |->
      pli_in[7:0] == pad_in[7:0])
      else $error("interconnect input lags a stable pin");
   irq_seen_c: cover property ($rose(irq));
   err_seen_c: cover property (pslverr);
   hold_seen_c: cover property (hold_mode && pad_oe != '0);
endmodule // gpb_port_block_chk

bind gpb_port_block gpb_port_block_chk #(.NUM_PORTS(NUM_PORTS), .PLI_PORTS(PLI_PORTS)) u_chk (
   .clk, .resetn, .psel, .penable, .pready, .pslverr, .hold_mode, .pad_in, .pad_out,
   .pad_oe, .pad_ie, .pad_pull_up, .pad_pull_down, .pli_in, .port_irq, .irq
);

// File: dv/gpb_port_block_tb.sv
// Self-checking bench for the I/O port block.
module gpb_port_block_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        hold_mode = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, pli_in;
   logic        pready, pslverr, irq;
   logic [7:0]  port_irq;
   logic [63:0] pad_in, pad_out, pad_oe, pad_ie, pad_pull_up, pad_pull_down, pad_weak;
   logic [63:0] pad_slow_slew, pad_low_voltage_ttl_threshold;
   logic [63:0] ff_out = 64'h0000_0000_c300_0000;
   logic [63:0] ff_oe = 64'h0000_0000_ff00_0000;
   logic [63:0] ext_val = 64'h0;
   logic [63:0] ext_en = 64'h0000_0000_0000_ff00;
   logic [31:0] pli_out = 32'h0000_005a;
   int          err_total = 0;
   int          checks = 0;
   int          cyc = 0;
   logic [7:0]  oe_t[8] = '{8'h00, 8'h00, 8'hf0, 8'h0f, 8'hf0, 8'h0f, 8'hff, 8'h00};
   logic [7:0]  mo_t[8] = '{8'h00, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h0f, 8'h0f, 8'h00};
   logic [7:0]  pu_t[8] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0f};
   logic [7:0]  pd_t[8] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'hf0};

   gpb_port_block u_dut (
      .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .hold_mode, .pad_in, .pad_out, .pad_oe, .pad_ie, .pad_pull_up, .pad_pull_down, .pad_weak,
      .pad_slow_slew, .pad_low_voltage_ttl_threshold, .ff_out, .ff_oe, .pli_out, .pli_in,
      .port_irq, .irq
   );
   gpb_pad_model u_pads (.pad_out, .pad_oe, .pad_pull_up, .pad_pull_down, .ext_val, .ext_en,
      .pad_in);

   always #20 clk = ~clk;

   task automatic give_verdict();
      if (err_total == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; returns the error flag above the read data.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [32:0] r);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = {pslverr, prdata};
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [32:0] r;
      apb(1'b1, a, d, r);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [32:0] x);
      logic [32:0] r;
      apb(1'b0, a, 32'h0, r);
      chk({31'h0, r}, {31'h0, x});
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         give_verdict();
      end
   end

   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      chk(pad_oe | pad_ie | pad_pull_up | pad_pull_down | pad_weak, 64'h0);
      for (int o = 0; o < 7; o++) if (o % 4 != 1) rdc(12'h1c0 + 12'(o * 4), 33'h0);
      rdc(12'h01c, 33'h1_0000_0000);
      wr(12'h080, 32'h0f);
      rdc(12'h080, 33'h0f);
      for (int c = 0; c < 8; c++) begin
         wr(12'h088, {8'h00, {8{c[2:0]}}});
         repeat (2) @(posedge clk);
         chk({pad_ie[23:16], pad_weak[23:16], pad_pull_down[23:16], pad_pull_up[23:16],
            pad_out[23:16] & pad_oe[23:16], pad_oe[23:16]}, {(c == 0) ? 8'h00 : 8'hff,
            (c == 7) ? 8'hff : 8'h00, pd_t[c], pu_t[c], mo_t[c], oe_t[c]});
      end
      rdc(12'h088, 33'hff_ffff);
      wr(12'h088, 32'h00db_6db6);
      wr(12'h08c, 32'h3ca5_ffff);
      repeat (2) @(posedge clk);
      chk({pad_slow_slew[23:16], pad_low_voltage_ttl_threshold[23:16], pad_oe[23:16],
         pad_ie[23:16]}, 64'h3ca5_0000);
      for (int p = 0; p < 5; p++) if (p == 0 || p > 2) begin
         wr(12'(p * 64 + 8), 32'h00db_6db6);
         wr(12'(p * 64 + 16), (p == 3) ? 32'h5555 : (p == 4) ? 32'hfaaa : 32'haaaa);
      end
      wr(12'h100, 32'h33);
      repeat (8) @(posedge clk);
      chk({pad_out[39:24], pad_out[7:0], pli_in[7:0]}, 64'h33c3_5a5a);
      wr(12'h200, 32'h1);
      rdc(12'h200, 33'h1);
      wr(12'h100, 32'hcc);
      repeat (2) @(posedge clk);
      chk(pad_out[39:32], 64'h33);
      hold_mode <= 1'b1;
      wr(12'h200, 32'h0);
      repeat (3) @(posedge clk);
      chk(pad_out[39:32], 64'h33);
      hold_mode <= 1'b0;
      repeat (3) @(posedge clk);
      chk(pad_out[39:32], 64'hcc);
      wr(12'h048, 32'h0024_9249);
      wr(12'h058, 32'h1);
      repeat (6) @(posedge clk);
      wr(12'h054, 32'hff);
      repeat (3) @(posedge clk);
      chk({port_irq, irq}, 64'h0);
      ext_val[8] <= 1'b1;
      repeat (8) @(posedge clk);
      chk({port_irq, irq}, 64'h5);
      rdc(12'h044, 33'h1);
      ext_val[9] <= 1'b1;
      repeat (8) @(posedge clk);
      rdc(12'h054, 33'h3);
      wr(12'h054, 32'h1);
      repeat (3) @(posedge clk);
      chk({port_irq, irq}, 64'h0);
      rdc(12'h054, 33'h2);
      wr(12'h04c, 32'hff);
      repeat (6) @(posedge clk);
      rdc(12'h044, 33'h0);
      resetn <= 1'b0;
      @(posedge clk);
      chk(pad_out | pad_oe | pad_ie | pad_pull_up | pad_pull_down | pad_weak, 64'h0);
      chk(pad_slow_slew | pad_low_voltage_ttl_threshold, 64'h0);
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
      chk(pad_oe | pad_ie | pad_pull_up | pad_pull_down, 64'h0);
      chk({pli_in, port_irq, irq}, 64'h0);
      rdc(12'h088, 33'h0);
      give_verdict();
   end
endmodule // gpb_port_block_tb

// File: hdl/gpb_pkg.sv
// Constants, register map and encodings of the general-purpose I/O port block.
// Summary of operation
// - Pins form eight-bit ports; each port's registers are one eight-bit unit.
// - During reset every pin driver is disabled, neither driving nor loading.
// - Each pin selects one of eight drive configurations by a three-bit code.
// - Each pin selects CMOS or low-voltage TTL input threshold.
// - Input path and output path of each pin disable independently.
// - While hold is active, every pin keeps its previous state unchanged.
// - Each pin has a software-selectable slow output slew setting.
// - A routing select picks each pin's source; fixed functions use dedicated inputs.
// - Only ports 0 to 3 connect to the programmable interconnect.
// - Output data register sets driven values; pin-state register returns pin levels.
// - Enabled pin interrupts combine into one request per port, eight in all.
package gpb_pkg;

   localparam int GPB_PORT_W    = 8;
   localparam int GPB_NUM_PORTS = 8;
   localparam int GPB_PLI_PORTS = 4;
   localparam int GPB_ADDR_W    = 12;
   localparam int GPB_MODE_W    = 3;
   localparam int GPB_ROUTE_W   = 2;

   // Port register blocks sit at a stride of 64 bytes; port index in paddr[8:6].
   localparam int GPB_PORT_LSB  = 6;
   localparam int GPB_PORT_MSB  = 8;
   localparam int GPB_AREA_LSB  = 9;

   localparam logic [5:0]  GPB_OFS_DOUT     = 6'h00;
   localparam logic [5:0]  GPB_OFS_PIN      = 6'h04;
   localparam logic [5:0]  GPB_OFS_MODE     = 6'h08;
   localparam logic [5:0]  GPB_OFS_CFG      = 6'h0c;
   localparam logic [5:0]  GPB_OFS_ROUTE    = 6'h10;
   localparam logic [5:0]  GPB_OFS_INT_STAT = 6'h14;
   localparam logic [5:0]  GPB_OFS_INT_MASK = 6'h18;
   localparam logic [11:0] GPB_OFS_HOLD     = 12'h200;

   // Fields of the per-port configuration word.
   localparam int GPB_CFG_IN_DIS  = 0;
   localparam int GPB_CFG_OUT_DIS = 8;
   localparam int GPB_CFG_THRESH  = 16;
   localparam int GPB_CFG_SLEW    = 24;

   localparam logic [31:0] GPB_CFG_RST   = 32'h0000_0000;
   localparam logic [23:0] GPB_MODE_RST  = 24'h00_0000;
   localparam logic [15:0] GPB_ROUTE_RST = 16'h0000;
   localparam logic [7:0]  GPB_BYTE_RST  = 8'h00;

   typedef enum logic [GPB_MODE_W-1:0] {
      GPB_DM_DISABLED,
      GPB_DM_INPUT_ONLY,
      GPB_DM_RES_PULL_UP,
      GPB_DM_RES_PULL_DOWN,
      GPB_DM_OPEN_DRAIN,
      GPB_DM_OPEN_SOURCE,
      GPB_DM_STRONG,
      GPB_DM_WEAK_PULL
   } gpb_drive_t;

   typedef enum logic [GPB_ROUTE_W-1:0] {
      GPB_ROUTE_DATA,
      GPB_ROUTE_FIXED,
      GPB_ROUTE_PLI,
      GPB_ROUTE_SPARE
   } gpb_route_t;

endpackage

// File: hdl/gpb_port_block.sv
// General-purpose I/O ports with APB registers, routing, hold and interrupts.
//
// Chosen here: register access over APB and the register addresses.
module gpb_port_block
   import gpb_pkg::*;
#(
   parameter int NUM_PORTS = GPB_NUM_PORTS,
   parameter int PLI_PORTS = GPB_PLI_PORTS
) (
   input  wire logic                              clk,
   input  wire logic                              resetn,
   input  wire logic                              psel,
   input  wire logic                              penable,
   input  wire logic                              pwrite,
   input  wire logic [GPB_ADDR_W-1:0]             paddr,
   input  wire logic [31:0]                       pwdata,
   output logic      [31:0]                       prdata,
   output logic                                   pready,
   output logic                                   pslverr,
   input  wire logic                              hold_mode,
   input  wire logic [NUM_PORTS*GPB_PORT_W-1:0]   pad_in,
   output logic      [NUM_PORTS*GPB_PORT_W-1:0]   pad_out,
   output logic      [NUM_PORTS*GPB_PORT_W-1:0]   pad_oe,
   output logic      [NUM_PORTS*GPB_PORT_W-1:0]   pad_ie,
   output logic      [NUM_PORTS*GPB_PORT_W-1:0]   pad_pull_up,
   output logic      [NUM_PORTS*GPB_PORT_W-1:0]   pad_pull_down,
   output logic      [NUM_PORTS*GPB_PORT_W-1:0]   pad_weak,
   output logic      [NUM_PORTS*GPB_PORT_W-1:0]   pad_slow_slew,
   output logic      [NUM_PORTS*GPB_PORT_W-1:0]   pad_low_voltage_ttl_threshold,
   input  wire logic [NUM_PORTS*GPB_PORT_W-1:0]   ff_out,
   input  wire logic [NUM_PORTS*GPB_PORT_W-1:0]   ff_oe,
   input  wire logic [PLI_PORTS*GPB_PORT_W-1:0]   pli_out,
   output logic      [PLI_PORTS*GPB_PORT_W-1:0]   pli_in,
   output logic      [NUM_PORTS-1:0]              port_irq,
   output logic                                   irq
);

   localparam int NPINS = NUM_PORTS * GPB_PORT_W;

   logic [GPB_PORT_W-1:0]          dout     [NUM_PORTS];
   logic [GPB_PORT_W*GPB_MODE_W-1:0] mode   [NUM_PORTS];
   logic [31:0]                    cfg      [NUM_PORTS];
   logic [GPB_PORT_W*GPB_ROUTE_W-1:0] route [NUM_PORTS];
   logic [GPB_PORT_W-1:0]          int_stat [NUM_PORTS];
   logic [GPB_PORT_W-1:0]          int_mask [NUM_PORTS];
   logic                           hold_sw;
   logic [NPINS-1:0]               pli_wide;
   logic [NPINS-1:0]               sync1;
   logic [NPINS-1:0]               sync2;
   logic [NPINS-1:0]               sync3;
   logic [NPINS-1:0]               pin_state;
   logic [NPINS-1:0]               next_pin_state;
   logic [NPINS-1:0]               next_out;
   logic [NPINS-1:0]               next_oe;
   logic [NPINS-1:0]               next_ie;
   logic [NPINS-1:0]               next_pu;
   logic [NPINS-1:0]               next_pd;
   logic [NPINS-1:0]               next_weak;
   logic [NPINS-1:0]               next_slew;
   logic [NPINS-1:0]               next_thresh;
   logic [NUM_PORTS-1:0]           next_port_irq;
   logic [31:0]                    rd_word;
   logic                           rd_hit;
   logic                           wr_fire;
   logic                           hold;
   logic [2:0]                     pidx;
   logic                           port_area;

   // Drive decode: returns {oe, out, pull_up, pull_down, weak} for a mode and data bit.
   function automatic logic [4:0] gpb_drive(input logic [GPB_MODE_W-1:0] m, input logic d);
      logic [4:0] r;
      r = 5'h00;
      case (gpb_drive_t'(m))
         GPB_DM_DISABLED:      r = 5'h00;
         GPB_DM_INPUT_ONLY:    r = 5'h00;
         GPB_DM_RES_PULL_UP:   r = {~d, 1'b0, 1'b1, 1'b0, 1'b0};
         GPB_DM_RES_PULL_DOWN: r = {d, 1'b1, 1'b0, 1'b1, 1'b0};
         GPB_DM_OPEN_DRAIN:    r = {~d, 1'b0, 1'b0, 1'b0, 1'b0};
         GPB_DM_OPEN_SOURCE:   r = {d, 1'b1, 1'b0, 1'b0, 1'b0};
         GPB_DM_STRONG:        r = {1'b1, d, 1'b0, 1'b0, 1'b0};
         GPB_DM_WEAK_PULL:     r = {1'b0, 1'b0, d, ~d, 1'b1};
         default:              r = 5'h00;
      endcase
      return r;
   endfunction

   assign pidx      = paddr[GPB_PORT_MSB:GPB_PORT_LSB];
   assign port_area = (paddr[GPB_ADDR_W-1:GPB_AREA_LSB] == '0) && (int'(pidx) < NUM_PORTS);
   assign wr_fire   = psel && penable && pready && pwrite && !pslverr;
   assign hold      = hold_mode | hold_sw;
   // Interconnect data widened to every pin so that no select runs past its top.
   assign pli_wide  = NPINS'(pli_out);

   // Read multiplexer and address decode.
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b0;
      if (paddr == GPB_OFS_HOLD) begin
         rd_hit  = 1'b1;
         rd_word = {31'h0000_0000, hold_sw};
      end else if (port_area) begin
         rd_hit = 1'b1;
         case (paddr[GPB_PORT_LSB-1:0])
            GPB_OFS_DOUT:     rd_word = {24'h00_0000, dout[pidx]};
            GPB_OFS_PIN:      rd_word = {24'h00_0000, pin_state[pidx*GPB_PORT_W +: GPB_PORT_W]};
            GPB_OFS_MODE:     rd_word = {8'h00, mode[pidx]};
            GPB_OFS_CFG:      rd_word = cfg[pidx];
            GPB_OFS_ROUTE:    rd_word = {16'h0000, route[pidx]};
            GPB_OFS_INT_STAT: rd_word = {24'h00_0000, int_stat[pidx]};
            GPB_OFS_INT_MASK: rd_word = {24'h00_0000, int_mask[pidx]};
            default:          rd_hit = 1'b0;
         endcase
      end
   end

   // APB slave: one wait state, answer registered.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         pready  <= 1'b1;
         prdata  <= pwrite ? 32'h0000_0000 : rd_word;
         pslverr <= !rd_hit;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Software-written port configuration, one eight-bit unit per port.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            dout[p]     <= GPB_BYTE_RST;
            mode[p]     <= GPB_MODE_RST;
            cfg[p]      <= GPB_CFG_RST;
            route[p]    <= GPB_ROUTE_RST;
            int_mask[p] <= GPB_BYTE_RST;
         end
      end else if (wr_fire && port_area) begin
         case (paddr[GPB_PORT_LSB-1:0])
            GPB_OFS_DOUT:     dout[pidx]     <= pwdata[GPB_PORT_W-1:0];
            GPB_OFS_MODE:     mode[pidx]     <= pwdata[GPB_PORT_W*GPB_MODE_W-1:0];
            GPB_OFS_CFG:      cfg[pidx]      <= pwdata;
            GPB_OFS_ROUTE:    route[pidx]    <= pwdata[GPB_PORT_W*GPB_ROUTE_W-1:0];
            GPB_OFS_INT_MASK: int_mask[pidx] <= pwdata[GPB_PORT_W-1:0];
            default:          dout[pidx]     <= dout[pidx];
         endcase
      end
   end

   // Software hold request.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hold_sw <= 1'b0;
      end else if (wr_fire && paddr == GPB_OFS_HOLD) begin
         hold_sw <= pwdata[0];
      end
   end

   // Three-stage pin input synchroniser.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
      end else begin
         sync1 <= pad_in;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // Pad control next values and accepted pin levels.
   always_comb begin
      logic [4:0]             drv;
      logic                   d;
      logic                   ffoe;
      logic [GPB_ROUTE_W-1:0] rs;
      logic [GPB_MODE_W-1:0]  m;
      drv  = 5'h00;
      d    = 1'b0;
      ffoe = 1'b1;
      rs   = '0;
      m    = '0;
      next_out       = '0;
      next_oe        = '0;
      next_ie        = '0;
      next_pu        = '0;
      next_pd        = '0;
      next_weak      = '0;
      next_slew      = '0;
      next_thresh    = '0;
      next_pin_state = pin_state;
      for (int p = 0; p < NUM_PORTS; p++) begin
         for (int b = 0; b < GPB_PORT_W; b++) begin
            rs   = route[p][b*GPB_ROUTE_W +: GPB_ROUTE_W];
            m    = mode[p][b*GPB_MODE_W +: GPB_MODE_W];
            d    = dout[p][b];
            ffoe = 1'b1;
            if (gpb_route_t'(rs) == GPB_ROUTE_FIXED) begin
               d    = ff_out[p*GPB_PORT_W+b];
               ffoe = ff_oe[p*GPB_PORT_W+b];
            end else if (gpb_route_t'(rs) == GPB_ROUTE_PLI && p < PLI_PORTS) begin
               d = pli_wide[p*GPB_PORT_W+b];
            end
            drv = gpb_drive(m, d);
            next_oe[p*GPB_PORT_W+b]   = drv[4] & ffoe & ~cfg[p][GPB_CFG_OUT_DIS+b];
            next_out[p*GPB_PORT_W+b]  = drv[3];
            next_pu[p*GPB_PORT_W+b]   = drv[2];
            next_pd[p*GPB_PORT_W+b]   = drv[1];
            next_weak[p*GPB_PORT_W+b] = drv[0];
            next_ie[p*GPB_PORT_W+b]   = (gpb_drive_t'(m) != GPB_DM_DISABLED)
                                        & ~cfg[p][GPB_CFG_IN_DIS+b];
            next_slew[p*GPB_PORT_W+b]   = cfg[p][GPB_CFG_SLEW+b];
            next_thresh[p*GPB_PORT_W+b] = cfg[p][GPB_CFG_THRESH+b];
            if (!pad_ie[p*GPB_PORT_W+b]) begin
               next_pin_state[p*GPB_PORT_W+b] = 1'b0;
            end else if (sync2[p*GPB_PORT_W+b] == sync3[p*GPB_PORT_W+b]) begin
               next_pin_state[p*GPB_PORT_W+b] = sync3[p*GPB_PORT_W+b];
            end
         end
      end
   end

   // Pad driver registers; frozen while hold is active.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pad_out                       <= '0;
         pad_oe                        <= '0;
         pad_ie                        <= '0;
         pad_pull_up                   <= '0;
         pad_pull_down                 <= '0;
         pad_weak                      <= '0;
         pad_slow_slew                 <= '0;
         pad_low_voltage_ttl_threshold <= '0;
      end else if (!hold) begin
         pad_out                       <= next_out;
         pad_oe                        <= next_oe;
         pad_ie                        <= next_ie;
         pad_pull_up                   <= next_pu;
         pad_pull_down                 <= next_pd;
         pad_weak                      <= next_weak;
         pad_slow_slew                 <= next_slew;
         pad_low_voltage_ttl_threshold <= next_thresh;
      end
   end

   // Pin state and interconnect feed.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pin_state <= '0;
         pli_in    <= '0;
      end else begin
         pin_state <= next_pin_state;
         pli_in    <= next_pin_state[PLI_PORTS*GPB_PORT_W-1:0];
      end
   end

   // Sticky pin-change flags; a new change wins over a write-one clear.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            int_stat[p] <= GPB_BYTE_RST;
         end
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            int_stat[p] <= (int_stat[p]
                            & ~((wr_fire && port_area && int'(pidx) == p
                                 && paddr[GPB_PORT_LSB-1:0] == GPB_OFS_INT_STAT)
                                ? pwdata[GPB_PORT_W-1:0] : GPB_BYTE_RST))
                           | (next_pin_state[p*GPB_PORT_W +: GPB_PORT_W]
                              ^ pin_state[p*GPB_PORT_W +: GPB_PORT_W]);
         end
      end
   end

   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         next_port_irq[p] = |(int_stat[p] & int_mask[p]);
      end
   end

   // One request per port and the combined level interrupt.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         port_irq <= '0;
         irq      <= 1'b0;
      end else begin
         port_irq <= next_port_irq;
         irq      <= |next_port_irq;
      end
   end

endmodule // gpb_port_block
